// File: pkg/ffs_defs.vh
// Constants for the function sequencer of the flexible-disk controller.
// Assumes inclusion by bare name from the sequencer module.
// Notes on behaviour
// - Fill buffer requests and stores each word
// - Word count follows mode, width and density
// - After done, transfers return error/status
// - Last word sets done, interrupt if enabled
// - Empty buffer presents words, buffer unchanged
// - Request only while a word waits
// - Write sector requests sector then track
// - Successful skip test clears transfer request
// - Density mismatch reports error and terminates
// - Write data plus CRC, buffer unchanged
// - Read sector requests sector then track
// - Illegal track ends with error and done
// - No header in two revolutions: code 70
// - Find data mark, move field into buffer
// - CRC failure sets bit 11, code 200
// - Deleted mark sets status bit 5
// - Code 100 in mode 1 only finishes
// - Key byte must be 0111, else 250
// - Seek track 0, write zero data fields
// - All sectors through track 76, stop on bad header
// - Density set rewrites data fields only
// - Legal track range is 0 to 76
`ifndef FFS_DEFS_VH
`define FFS_DEFS_VH
`define FFS_FN_FILL 3'h0
`define FFS_FN_EMPTY 3'h1
`define FFS_FN_WRITE 3'h2
`define FFS_FN_READ 3'h3
`define FFS_FN_DENSITY 3'h4
`define FFS_WORDS_128 9'h080
`define FFS_WORDS_64 9'h040
`define FFS_WORDS_256 9'h100
`define FFS_TRACK_MAX 7'h4C
`define FFS_SECTOR_MAX 5'h1A
`define FFS_KEY_BYTE 12'h049
`define FFS_ERR_NO_HDR 8'h38
`define FFS_ERR_CRC 8'h80
`define FFS_ERR_KEY 8'hA8
`define FFS_ERR_TRACK 8'h28
`define FFS_ERR_DENSITY 8'hF0
`define FFS_ST_DELETED 5
`define FFS_ST_DRV_DEN 6
`define FFS_ST_DEN_ERR 7
`define FFS_ST_CRC 11
`define FFS_REVS_MAX 2'h2
`endif

// File: rtl/ffs_sequencer.v
// Function sequencer: runs host functions over the interface register handshake.
// Assumes a disk-side engine on the same clock that acts on one-cycle strobes.
//
`timescale 1ns/1ps
`default_nettype none
`include "ffs_defs.vh"
module ffs_sequencer (
    // Clock and reset.
    input wire clk_in,
    input wire rst_in,
    // Host command and flag instructions; load, skip and transfer strobes are one-cycle pulses, mode2 and interrupt enable are levels.
    input wire cmd_load_in,
    input wire [2:0] cmd_func_in,
    input wire cmd_density_in,
    input wire cmd_byte_mode_in,
    input wire mode2_in,
    input wire int_enable_in,
    input wire skip_tr_in,
    input wire xfer_wr_in,
    input wire xfer_rd_in,
    input wire [11:0] xfer_data_in,
    // Host view.
    output reg [11:0] xfer_data_out,
    output reg tr_flag_out,
    output reg done_flag_out,
    output reg err_flag_out,
    output reg irq_out,
    output reg skip_taken_out,
    // Disk engine requests.
    output reg disk_start_out,
    output reg [1:0] disk_op_out,
    output reg [6:0] disk_track_out,
    output reg [4:0] disk_sector_out,
    output reg [11:0] disk_wdata_out,
    // Disk engine answers; disk_op: 0 write, 1 read, 2 density fill.
    input wire disk_density_in,
    input wire disk_rdata_valid_in,
    input wire [11:0] disk_rdata_in,
    input wire disk_wdata_req_in,
    input wire disk_index_in,
    input wire disk_hdr_found_in,
    input wire disk_bad_hdr_in,
    input wire disk_deleted_in,
    input wire disk_crc_ok_in,
    input wire disk_done_in
);
    // State codes.
    // Waiting for a command.
    localparam [3:0] S_IDLE = 4'h0;
    // Taking buffer words from the host.
    localparam [3:0] S_FILL = 4'h1;
    // Handing buffer words to the host.
    localparam [3:0] S_EMPTY = 4'h2;
    // Waiting for the sector address.
    localparam [3:0] S_SECT = 4'h3;
    // Waiting for the track address.
    localparam [3:0] S_TRK = 4'h4;
    // Disk engine at work.
    localparam [3:0] S_DISK = 4'h5;
    // Waiting for the key byte.
    localparam [3:0] S_KEY = 4'h6;
    // Completion: status out, done up.
    localparam [3:0] S_FIN = 4'h7;

    // Sector buffer, 256 words.
    reg [11:0] buf_mem [0:255];
    // Current state.
    reg [3:0] state_ff;
    // Function code of the running command.
    reg [2:0] func_ff;
    // Word width: high for 8-bit words.
    reg den_ff;
    // Buffer word index.
    reg [8:0] idx_ff;
    // Words in one buffer for this command.
    reg [8:0] limit_ff;
    // Error/status register.
    reg [11:0] status_ff;
    // Error code register.
    reg [7:0] code_ff;
    // Error seen during the running command.
    reg err_ff;
    // Revolutions without a matching header.
    reg [1:0] revs_ff;
    // Track address from the host.
    reg [6:0] dtrack_ff;
    // Sector address from the host.
    reg [4:0] dsect_ff;

    // Two-stage synchronisers for the disk-side density and index pins.
    // Density pin, first stage.
    reg den_s1_ff;
    // Density pin, safe to read.
    reg den_s2_ff;
    // Index pin, first stage.
    reg idx_s1_ff;
    // Index pin, safe to read.
    reg idx_s2_ff;
    // Index pin delayed once for edge finding.
    reg idx_s3_ff;
    wire index_pulse = idx_s2_ff & ~idx_s3_ff;

    // Word count from mode, word width and density.
    function [8:0] ffs_words;
        input m2;
        input byte_mode;
        input dd;
        begin
            if (!m2) begin
                ffs_words = byte_mode ? `FFS_WORDS_128 : `FFS_WORDS_64;
            end else if (byte_mode) begin
                ffs_words = dd ? `FFS_WORDS_256 : `FFS_WORDS_128;
            end else begin
                ffs_words = dd ? `FFS_WORDS_128 : `FFS_WORDS_64;
            end
        end
    endfunction

    // Width mask for the host data word.
    function [11:0] ffs_mask;
        input byte_mode;
        input [11:0] d;
        begin
            ffs_mask = byte_mode ? {4'h0, d[7:0]} : d;
        end
    endfunction

    // Synchronisers; first stage feeds only the second.
    always @(posedge clk_in) begin
        den_s1_ff <= disk_density_in;
        den_s2_ff <= den_s1_ff;
        idx_s1_ff <= disk_index_in;
        idx_s2_ff <= idx_s1_ff;
        idx_s3_ff <= idx_s2_ff;
    end

    // Buffer write port: fill from host, read data from disk.
    always @(posedge clk_in) begin
        if (state_ff == S_FILL && xfer_wr_in && !tr_flag_out) begin
            buf_mem[idx_ff[7:0]] <= ffs_mask(den_ff, xfer_data_in);
        end else if (state_ff == S_DISK && func_ff == `FFS_FN_READ && disk_rdata_valid_in) begin
            buf_mem[idx_ff[7:0]] <= disk_rdata_in;
        end
    end

    // Main sequencer.
    always @(posedge clk_in) begin
        if (rst_in) begin
            // Reset clears every sequencer register and flag; the buffer and the synchronisers are not reset.
            state_ff <= S_IDLE;
            func_ff <= 3'h0;
            den_ff <= 1'b0;
            idx_ff <= 9'h000;
            limit_ff <= 9'h000;
            status_ff <= 12'h000;
            code_ff <= 8'h00;
            err_ff <= 1'b0;
            revs_ff <= 2'h0;
            dtrack_ff <= 7'h00;
            dsect_ff <= 5'h00;
            // Host-visible outputs start idle.
            xfer_data_out <= 12'h000;
            tr_flag_out <= 1'b0;
            done_flag_out <= 1'b0;
            err_flag_out <= 1'b0;
            irq_out <= 1'b0;
            skip_taken_out <= 1'b0;
            // Disk requests start idle.
            disk_start_out <= 1'b0;
            disk_op_out <= 2'h0;
            disk_track_out <= 7'h00;
            disk_sector_out <= 5'h00;
            disk_wdata_out <= 12'h000;
        end else begin
            disk_start_out <= 1'b0;
            irq_out <= 1'b0;
            // Skip test succeeds only while the request stands, and clears it.
            skip_taken_out <= skip_tr_in & tr_flag_out;
            if (skip_tr_in && tr_flag_out) begin
                tr_flag_out <= 1'b0;
            end
            case (state_ff)
                S_IDLE: begin
                    // Idle: wait for a command.
                    if (cmd_load_in) begin
                        // Latch the function and its word count.
                        func_ff <= cmd_func_in;
                        den_ff <= cmd_byte_mode_in;
                        limit_ff <= ffs_words(mode2_in, cmd_byte_mode_in, cmd_density_in);
                        status_ff[`FFS_ST_DRV_DEN] <= den_s2_ff;
                        idx_ff <= 9'h000;
                        done_flag_out <= 1'b0;
                        err_flag_out <= 1'b0;
                        err_ff <= 1'b0;
                        revs_ff <= 2'h0;
                        if (cmd_func_in == `FFS_FN_FILL) begin
                            // Fill: ask for the first word.
                            state_ff <= S_FILL;
                            tr_flag_out <= 1'b1;
                        end else if (cmd_func_in == `FFS_FN_EMPTY) begin
                            // Empty: the first word loads next cycle.
                            state_ff <= S_EMPTY;
                        end else if (cmd_func_in == `FFS_FN_WRITE || cmd_func_in == `FFS_FN_READ) begin
                            // Clear status; bit 6 takes the drive density, bit 7 keeps the command density for now.
                            status_ff <= ({11'h000, den_s2_ff} << `FFS_ST_DRV_DEN)
                                | ({11'h000, cmd_density_in} << `FFS_ST_DEN_ERR);
                            tr_flag_out <= 1'b1;
                            state_ff <= S_SECT;
                        end else if (cmd_func_in == `FFS_FN_DENSITY && mode2_in) begin
                            // Bit 7 carries the wanted density to the key step.
                            status_ff[`FFS_ST_DEN_ERR] <= cmd_density_in;
                            tr_flag_out <= 1'b1;
                            state_ff <= S_KEY;
                        end else begin
                            // Mode 1 density code and others just finish.
                            state_ff <= S_FIN;
                        end
                    end else if (xfer_rd_in && done_flag_out) begin
                        // After done, a read reloads status.
                        xfer_data_out <= status_ff;
                    end
                end
                S_FILL: begin
                    // Each word is taken once its request has been tested.
                    if (xfer_wr_in && !tr_flag_out) begin
                        if (idx_ff + 9'h001 == limit_ff) begin
                            state_ff <= S_FIN;
                        end else begin
                            idx_ff <= idx_ff + 9'h001;
                            tr_flag_out <= 1'b1;
                        end
                    end
                end
                S_EMPTY: begin
                    // Load the next word, then raise the request for it.
                    if (!tr_flag_out && (idx_ff == 9'h000 || xfer_rd_in)) begin
                        if (idx_ff == limit_ff) begin
                            state_ff <= S_FIN;
                        end else begin
                            xfer_data_out <= ffs_mask(den_ff, buf_mem[idx_ff[7:0]]);
                            tr_flag_out <= 1'b1;
                            idx_ff <= idx_ff + 9'h001;
                        end
                    end
                end
                S_SECT: begin
                    // Take the sector, then ask for the track.
                    if (xfer_wr_in && !tr_flag_out) begin
                        dsect_ff <= xfer_data_in[4:0];
                        tr_flag_out <= 1'b1;
                        state_ff <= S_TRK;
                    end
                end
                S_TRK: begin
                    // Check track and density before starting the engine.
                    if (xfer_wr_in && !tr_flag_out) begin
                        dtrack_ff <= xfer_data_in[6:0];
                        idx_ff <= 9'h000;
                        if (xfer_data_in > {5'h00, `FFS_TRACK_MAX}) begin
                            status_ff[`FFS_ST_DEN_ERR] <= 1'b0;
                            code_ff <= `FFS_ERR_TRACK;
                            err_ff <= 1'b1;
                            state_ff <= S_FIN;
                        end else if (mode2_in ? (status_ff[`FFS_ST_DEN_ERR] != den_s2_ff)
                                              : den_s2_ff) begin
                            status_ff[`FFS_ST_DEN_ERR] <= 1'b1;
                            code_ff <= `FFS_ERR_DENSITY;
                            err_ff <= 1'b1;
                            state_ff <= S_FIN;
                        end else begin
                            status_ff[`FFS_ST_DEN_ERR] <= 1'b0;
                            disk_op_out <= (func_ff == `FFS_FN_WRITE) ? 2'h0 : 2'h1;
                            disk_track_out <= xfer_data_in[6:0];
                            disk_sector_out <= dsect_ff;
                            disk_start_out <= 1'b1;
                            state_ff <= S_DISK;
                        end
                    end
                end
                S_KEY: begin
                    // Only the right key byte starts the whole-disk fill.
                    if (xfer_wr_in && !tr_flag_out) begin
                        if (xfer_data_in != `FFS_KEY_BYTE) begin
                            code_ff <= `FFS_ERR_KEY;
                            err_ff <= 1'b1;
                            state_ff <= S_FIN;
                        end else begin
                            // Engine walks tracks 0..76, sectors 1..26, data fields only.
                            disk_op_out <= 2'h2;
                            disk_track_out <= 7'h00;
                            disk_sector_out <= 5'h01;
                            disk_wdata_out <= 12'h000;
                            disk_start_out <= 1'b1;
                            status_ff[`FFS_ST_DRV_DEN] <= status_ff[`FFS_ST_DEN_ERR];
                            status_ff[`FFS_ST_DEN_ERR] <= 1'b0;
                            state_ff <= S_DISK;
                        end
                    end
                end
                S_DISK: begin
                    // Write source data from the unchanged buffer.
                    if (disk_wdata_req_in && func_ff == `FFS_FN_WRITE) begin
                        disk_wdata_out <= buf_mem[idx_ff[7:0]];
                        idx_ff <= idx_ff + 9'h001;
                    end
                    if (disk_rdata_valid_in && func_ff == `FFS_FN_READ) begin
                        idx_ff <= idx_ff + 9'h001;
                    end
                    if (index_pulse && !disk_hdr_found_in && func_ff != `FFS_FN_DENSITY) begin
                        revs_ff <= revs_ff + 2'h1;
                    end
                    if (disk_bad_hdr_in && func_ff == `FFS_FN_DENSITY) begin
                        err_ff <= 1'b1;
                        state_ff <= S_FIN;
                    end else if (revs_ff == `FFS_REVS_MAX) begin
                        // Two revolutions without a header end the transfer.
                        code_ff <= `FFS_ERR_NO_HDR;
                        err_ff <= 1'b1;
                        state_ff <= S_FIN;
                    end else if (disk_done_in) begin
                        // The engine's done ends every transfer.
                        if (func_ff == `FFS_FN_READ) begin
                            status_ff[`FFS_ST_DELETED] <= disk_deleted_in;
                            if (!disk_crc_ok_in) begin
                                status_ff[`FFS_ST_CRC] <= 1'b1;
                                code_ff <= `FFS_ERR_CRC;
                                err_ff <= 1'b1;
                            end
                        end
                        state_ff <= S_FIN;
                    end
                end
                S_FIN: begin
                    // Completion: status to interface, done, optional interrupt.
                    xfer_data_out <= status_ff;
                    tr_flag_out <= 1'b0;
                    done_flag_out <= 1'b1;
                    err_flag_out <= err_ff;
                    irq_out <= int_enable_in;
                    state_ff <= S_IDLE;
                end
                default: begin
                    // Unused codes fall back to idle.
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: dv/ffs_disk_model.sv
// Disk engine stand-in: answers a start with header, data and done pulses.
// Assumes the sequencer's clock; behaviour is set by levels from the bench.
`timescale 1ns/1ps
`default_nettype none
module ffs_disk_model (
    // Clock and request.
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [1:0] op_in,
    // Behaviour chosen by the bench.
    input wire logic [8:0] words_in,
    input wire logic hdr_ok_in,
    // Answers to the sequencer.
    output logic hdr_out,
    output logic rvld_out,
    output logic wreq_out,
    output logic index_out,
    output logic bad_out,
    output logic done_out,
    output logic [11:0] rdata_out
);
    logic [15:0] cnt; // Cycles since the latest start.
    logic run; // High once any start was seen.
    logic in_data; // High in the data window.
    initial run = 1'b0;
    // Count from each start so every answer has a fixed place.
    always @(posedge clk_in) begin
        cnt <= start_in ? 16'h0000 : cnt + 16'h0001;
        run <= run | start_in;
    end
    assign in_data = run && hdr_ok_in && cnt > 16'h0003 && cnt < {7'h00, words_in} + 16'h0004;
    assign hdr_out = run && hdr_ok_in && cnt == 16'h0002;
    assign rvld_out = in_data && op_in == 2'h1;
    assign wreq_out = in_data && op_in == 2'h0;
    assign done_out = run && hdr_ok_in && cnt == {7'h00, words_in} + 16'h0006;
    // Without a header, index edges come only while the count since the start is below 512.
    assign index_out = run && !hdr_ok_in && cnt < 16'h0200 && cnt[3];
    assign bad_out = run && !hdr_ok_in && op_in == 2'h2 && cnt == 16'h0002;
    // Outside the data window the data lines show the inverse, never a stale word.
    assign rdata_out = rvld_out ? cnt[11:0] ^ 12'h5A3 : ~(cnt[11:0] ^ 12'h5A3);
endmodule
`default_nettype wire

// File: dv/ffs_sequencer_props.sv
// Checker for the sequencer's flag handshake and completion timing.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ffs_sequencer_props (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Host side.
    input wire logic cmd_load_in,
    input wire logic int_enable_in,
    input wire logic skip_tr_in,
    input wire logic [11:0] xfer_data_out,
    input wire logic tr_flag_out,
    input wire logic done_flag_out,
    input wire logic err_flag_out,
    input wire logic irq_out,
    input wire logic skip_taken_out,
    // Disk side.
    input wire logic disk_start_out,
    input wire logic [6:0] disk_track_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    skip_clears_a: assert property (
        skip_tr_in && tr_flag_out |=> !tr_flag_out && skip_taken_out) else $error("skip kept request");
    tr_fall_cause_a: assert property (
        $fell(tr_flag_out) |-> $past(skip_tr_in)) else $error("request dropped without skip");
    irq_enabled_a: assert property (
        irq_out |-> int_enable_in ##[0:1] done_flag_out) else $error("stray interrupt");
    done_irq_a: assert property (
        $rose(done_flag_out) && int_enable_in |-> $past(irq_out) or ##[0:1] irq_out)
        else $error("done without interrupt");
    done_holds_a: assert property (
        $fell(done_flag_out) |-> $past(cmd_load_in)) else $error("done dropped early");
    tr_done_excl_a: assert property (
        done_flag_out |-> !tr_flag_out) else $error("request while done");
    err_done_a: assert property (
        $rose(err_flag_out) |-> ##[0:2] done_flag_out) else $error("error without done");
    status_held_a: assert property (
        done_flag_out && $past(done_flag_out) && $past(done_flag_out, 2) && !$past(cmd_load_in)
        |-> $stable(xfer_data_out)) else $error("status changed after done");
    track_legal_a: assert property (
        disk_start_out |-> disk_track_out <= 7'h4C) else $error("illegal track started");
    start_quiet_a: assert property (
        disk_start_out |-> !tr_flag_out && !done_flag_out) else $error("disk start mid handshake");
endmodule
bind ffs_sequencer ffs_sequencer_props u_props (.clk_in, .rst_in, .cmd_load_in, .int_enable_in,
    .skip_tr_in, .xfer_data_out, .tr_flag_out, .done_flag_out, .err_flag_out, .irq_out,
    .skip_taken_out, .disk_start_out, .disk_track_out);
`default_nettype wire

// File: dv/ffs_sequencer_bench.sv
// Self-checking bench: host handshakes for every function, disk model behind.
// Assumes the sequencer, its constants header and the disk model.
`timescale 1ns/1ps
`default_nettype none
`include "ffs_defs.vh"
module ffs_sequencer_bench;
    logic clk_in, rst_in, cmd_load_in, cmd_density_in, cmd_byte_mode_in, mode2_in, int_enable_in;
    logic skip_tr_in, xfer_wr_in, xfer_rd_in, disk_density_in, disk_deleted_in, disk_crc_ok_in;
    logic hdr_ok; // Disk model finds headers.
    logic [2:0] cmd_func_in;
    logic [11:0] xfer_data_in;
    logic [8:0] words; // Words the disk model streams.
    logic [6:0] first_trk; // Track of the first start after a command.
    logic [4:0] first_sec; // Sector of that start.
    wire [11:0] xfer_data_out, disk_wdata_out, disk_rdata_in;
    wire tr_flag_out, done_flag_out, err_flag_out, irq_out, skip_taken_out, disk_start_out;
    wire disk_rdata_valid_in, disk_wdata_req_in, disk_index_in, disk_hdr_found_in;
    wire disk_bad_hdr_in, disk_done_in;
    wire [1:0] disk_op_out;
    wire [6:0] disk_track_out;
    wire [4:0] disk_sector_out;
    int mismatches, checked, irqs, starts;
    ffs_sequencer u_dut (.clk_in, .rst_in, .cmd_load_in, .cmd_func_in, .cmd_density_in,
        .cmd_byte_mode_in, .mode2_in, .int_enable_in, .skip_tr_in, .xfer_wr_in, .xfer_rd_in,
        .xfer_data_in, .xfer_data_out, .tr_flag_out, .done_flag_out, .err_flag_out, .irq_out,
        .skip_taken_out, .disk_start_out, .disk_op_out, .disk_track_out, .disk_sector_out,
        .disk_wdata_out, .disk_density_in, .disk_rdata_valid_in, .disk_rdata_in,
        .disk_wdata_req_in, .disk_index_in, .disk_hdr_found_in, .disk_bad_hdr_in,
        .disk_deleted_in, .disk_crc_ok_in, .disk_done_in);
    ffs_disk_model u_disk (.clk_in, .start_in(disk_start_out), .op_in(disk_op_out),
        .words_in(words), .hdr_ok_in(hdr_ok), .hdr_out(disk_hdr_found_in),
        .rvld_out(disk_rdata_valid_in), .wreq_out(disk_wdata_req_in), .index_out(disk_index_in),
        .bad_out(disk_bad_hdr_in), .done_out(disk_done_in), .rdata_out(disk_rdata_in));
    // Clock at 40 MHz.
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Counts interrupts and notes where the disk was first sent.
    always @(posedge clk_in) begin
        if (irq_out === 1'b1) irqs++;
        if (disk_start_out === 1'b1) begin
            if (starts == 0) {first_trk, first_sec} = {disk_track_out, disk_sector_out};
            starts++;
        end
    end
    function automatic logic [11:0] pat(input int i, input logic b);
        return (b ? 12'h0FF : 12'hFFF) & (12'(i) * 12'h02B + 12'h09C);
    endfunction
    task chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick;
        @(posedge clk_in);
        #1;
    endtask
    task cmd(input logic [2:0] f, input logic d, input logic b);
        starts = 0;
        @(posedge clk_in);
        {cmd_func_in, cmd_density_in, cmd_byte_mode_in, cmd_load_in} <= {f, d, b, 1'b1};
        @(posedge clk_in);
        cmd_load_in <= 1'b0;
    endtask
    // Host polls the request flag, then skips on it.
    task take_request;
        int n;
        n = 0;
        do begin tick(); n++; end while (tr_flag_out !== 1'b1 && n < 400);
        chk({11'h000, tr_flag_out}, 12'h001);
        @(posedge clk_in);
        skip_tr_in <= 1'b1;
        @(posedge clk_in);
        skip_tr_in <= 1'b0;
    endtask
    task put(input logic [11:0] w);
        take_request();
        {xfer_wr_in, xfer_data_in} <= {1'b1, w};
        @(posedge clk_in);
        xfer_wr_in <= 1'b0;
    endtask
    task get(output logic [11:0] w);
        take_request();
        xfer_rd_in <= 1'b1;
        #1 w = xfer_data_out;
        @(posedge clk_in);
        xfer_rd_in <= 1'b0;
    endtask
    task wait_done(input int lim, input logic e);
        int n;
        n = 0;
        do begin tick(); n++; end while (done_flag_out !== 1'b1 && n < lim);
        chk({10'h000, done_flag_out, err_flag_out}, {10'h000, 1'b1, e});
    endtask
    task t_buffer(input logic m2, input logic b, input logic d, input logic ie, input int n);
        logic [11:0] w;
        int i0;
        {mode2_in, int_enable_in} <= {m2, ie};
        i0 = irqs;
        cmd(`FFS_FN_FILL, d, b);
        for (int i = 0; i < n; i++) put(pat(i, 1'b0));
        wait_done(100, 1'b0);
        tick(); // The interrupt pulse is counted one edge later.
        chk(12'(irqs - i0), {11'h000, ie});
        cmd(`FFS_FN_EMPTY, d, b);
        for (int i = 0; i < n; i++) begin
            get(w);
            chk(w, pat(i, b));
        end
        wait_done(100, 1'b0);
        w = xfer_data_out;
        xfer_rd_in <= 1'b1;
        tick();
        xfer_rd_in <= 1'b0;
        tick();
        chk(xfer_data_out, w);
        $display("buffer test of %0d words done", n);
    endtask
    task t_func(input logic [2:0] f, input logic d, input logic [6:0] t, input logic e,
        input logic [11:0] m, input logic [11:0] x);
        cmd(f, d, 1'b1);
        put(12'h001);
        put({5'h00, t});
        wait_done(2000, e);
        chk(xfer_data_out & m, x);
        $display("sector test on track %0d done", t);
    endtask
    task t_key(input logic [11:0] k, input logic e);
        cmd(`FFS_FN_DENSITY, 1'b0, 1'b1);
        put(k);
        wait_done(60000, e);
        $display("density test done");
    endtask
    task report_and_stop;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        {cmd_load_in, cmd_density_in, cmd_byte_mode_in, mode2_in, int_enable_in} = 5'h00;
        {skip_tr_in, xfer_wr_in, xfer_rd_in, cmd_func_in, xfer_data_in} = 18'h00000;
        {disk_density_in, disk_deleted_in, disk_crc_ok_in, hdr_ok, words, rst_in} = 14'h1F01;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        t_buffer(1'b0, 1'b1, 1'b0, 1'b1, 128);
        t_buffer(1'b0, 1'b0, 1'b0, 1'b0, 64);
        t_buffer(1'b1, 1'b1, 1'b1, 1'b1, 256);
        t_buffer(1'b1, 1'b1, 1'b0, 1'b0, 128);
        t_buffer(1'b1, 1'b0, 1'b1, 1'b1, 128);
        t_buffer(1'b1, 1'b0, 1'b0, 1'b0, 64);
        mode2_in <= 1'b0;
        t_func(`FFS_FN_WRITE, 1'b0, 7'h4C, 1'b0, 12'h880, 12'h000);
        chk({5'h00, first_trk}, 12'h04C);
        chk({7'h00, first_sec}, 12'h001);
        t_func(`FFS_FN_READ, 1'b0, 7'h4D, 1'b1, 12'h000, 12'h000);
        hdr_ok <= 1'b0;
        t_func(`FFS_FN_READ, 1'b0, 7'h05, 1'b1, 12'h000, 12'h000);
        {hdr_ok, disk_crc_ok_in, disk_deleted_in} <= 3'h5;
        t_func(`FFS_FN_READ, 1'b0, 7'h03, 1'b1, 12'h820, 12'h820);
        {mode2_in, disk_crc_ok_in, disk_deleted_in, words} <= {3'h6, 9'h100};
        t_func(`FFS_FN_WRITE, 1'b1, 7'h03, 1'b1, 12'h080, 12'h080);
        {hdr_ok, words} <= {1'b0, 9'h001};
        t_key(`FFS_KEY_BYTE, 1'b1);
        hdr_ok <= 1'b1;
        t_key(12'h048, 1'b1);
        t_key(`FFS_KEY_BYTE, 1'b0);
        chk({5'h00, first_trk}, 12'h000);
        chk({7'h00, first_sec}, 12'h001);
        mode2_in <= 1'b0;
        cmd(`FFS_FN_DENSITY, 1'b0, 1'b1);
        wait_done(100, 1'b0);
        chk(12'(starts), 12'h000);
        $display("set density in mode 1 done");
        report_and_stop();
    end
endmodule
`default_nettype wire
